// ===== rtl/tws_pkg.sv
package tws_pkg;

   // ======================================================
   // Timing
   // ======================================================
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned INSTR_CYCLE_NS = 1000;
   localparam int unsigned TC_CYCLES = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Half periods of the master shift clock: 1, 2 and 4 instruction cycles
   localparam logic [9:0] HALF_2TC = 10'(TC_CYCLES);
   localparam logic [9:0] HALF_4TC = 10'(2 * TC_CYCLES);
   localparam logic [9:0] HALF_8TC = 10'(4 * TC_CYCLES);
   localparam logic [9:0] CNT_ONE = 10'h001;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [2:0] BIT_ONE = 3'h1;

   // ======================================================
   // Register map (byte addresses)
   // ======================================================
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_PORT_G = 8'h04;
   localparam logic [7:0] ADDR_PSW = 8'h08;
   localparam logic [7:0] ADDR_SHIFT = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

   // ======================================================
   // Field positions
   // ======================================================
   localparam int unsigned CTRL_SERIAL_SELECT = 0;
   localparam int unsigned CTRL_RATE_LO = 1;
   localparam int unsigned CTRL_RATE_HI = 2;
   localparam int unsigned PG_BIT4 = 4;
   localparam int unsigned PG_BIT5 = 5;
   localparam int unsigned PG_BIT6 = 6;
   localparam int unsigned PSW_BUSY = 0;
   localparam int unsigned IRQ_DONE = 0;

   // ======================================================
   // Reset values
   // ======================================================
   localparam logic [2:0] CONTROL_RESET = 3'h0;
   localparam logic [2:0] PORT_G_RESET = 3'h0;
   localparam logic [7:0] SHIFT_RESET = 8'h00;

   // ======================================================
   // Transfer state
   // ======================================================
   typedef enum logic [1:0] {
      TWS_IDLE = 2'b01,
      TWS_SHIFT = 2'b10
   } tws_state_t;

endpackage : tws_pkg

// ===== rtl/tws_shifter.sv
// Summary of operation
// - Eight-bit shift register between data pins.
// - Internal clock is master, external is slave.
// - Port works only with serial_select set.
// - Master clock period two, four, eight cycles.
// - Busy starts shifting, clears after eight bits.
// - Software clearing busy aborts transfer early.
// - Enabled interrupt after eight bits shifted.
// - Shift clock rests low when idle.
// - Master generates clock and initiates exchanges.
// - Bit4 drives output, bit5 picks clock source.
// - Normal phase: sample rising, shift falling.
// - Alternate phase shifts on rising edge.
// - Bit6 selects normal or alternate phase.
// - Phase select resets to normal.
`timescale 1ns/1ps
`default_nettype none

module tws_shifter
   import tws_pkg::*;
(
   input wire logic pclk, // System clock, 200 MHz
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction, high for write
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   output logic irq, // Level interrupt
   input wire logic serial_in_pin, // Serial data input pin
   output logic serial_out_o, // Serial data output pin value
   output logic serial_out_oe, // Serial data output enable
   input wire logic shift_clock_pin_i, // Shift clock pin level
   output logic shift_clock_pin_o, // Shift clock pin drive value
   output logic shift_clock_pin_oe // Shift clock pin output enable
);

   // ======================================================
   // Declarations
   // ======================================================
   logic [2:0] control;
   logic [2:0] port_g;
   logic [7:0] serial_shift_reg;
   logic irq_status;
   logic irq_mask;
   tws_state_t state;
   tws_state_t next_state;
   logic [2:0] bit_cnt;
   logic [9:0] half_cnt;
   logic [9:0] half_period;
   logic sk_master;
   logic sk_sync;
   logic sk_prev;
   logic si_sync;
   logic in_bit;
   logic serial_select;
   logic port_g_bit4;
   logic port_g_bit5;
   logic clock_phase_select;
   logic busy;
   logic active;
   logic is_master;
   logic tick;
   logic rise;
   logic fall;
   logic shift_edge;
   logic last_edge;
   logic setup_phase;
   logic access_wr;
   logic access_rd;
   logic wr_psw;
   logic wr_shift;
   logic rd_irq;

   // ======================================================
   // Pin input synchronisers
   // ======================================================
   // Both incoming pins pass two flip-flops before use
   tws_sync u_sync_sk
   (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(shift_clock_pin_i),
      .sync_out(sk_sync)
   );

   tws_sync u_sync_si
   (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(serial_in_pin),
      .sync_out(si_sync)
   );

   // ======================================================
   // Decoded controls
   // ======================================================
   // Control fields
   assign serial_select = control[CTRL_SERIAL_SELECT];
   assign port_g_bit4 = port_g[PG_BIT4 - PG_BIT4];
   assign port_g_bit5 = port_g[PG_BIT5 - PG_BIT4];
   assign clock_phase_select = port_g[PG_BIT6 - PG_BIT4];
   assign busy = (state == TWS_SHIFT);
   assign is_master = port_g_bit5;
   assign active = busy && serial_select;

   // Master half period from the rate select bits
   assign half_period = control[CTRL_RATE_HI] ? HALF_8TC : (control[CTRL_RATE_LO] ? HALF_4TC : HALF_2TC);

   // ======================================================
   // APB decode
   // ======================================================
   // Zero wait states; read data is captured in the setup cycle
   assign pready = 1'b1;
   assign setup_phase = psel && !penable;
   assign access_wr = psel && penable && pwrite;
   assign access_rd = psel && penable && !pwrite;
   assign wr_psw = access_wr && (paddr == ADDR_PSW);
   assign wr_shift = access_wr && (paddr == ADDR_SHIFT);
   assign rd_irq = access_rd && (paddr == ADDR_IRQ_STATUS);

   // Configuration registers written by software
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         control <= CONTROL_RESET;
         port_g <= PORT_G_RESET;
         irq_mask <= 1'b0;
      end
      else if (access_wr)
      begin
         if (paddr == ADDR_CONTROL)
         begin
            control <= pwdata[CTRL_RATE_HI:CTRL_SERIAL_SELECT];
         end
         if (paddr == ADDR_PORT_G)
         begin
            port_g <= pwdata[PG_BIT6:PG_BIT4];
         end
         if (paddr == ADDR_IRQ_MASK)
         begin
            irq_mask <= pwdata[IRQ_DONE];
         end
      end
   end

   // Read data and error, registered during the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (setup_phase)
      begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         unique case (paddr)
            ADDR_CONTROL: prdata[CTRL_RATE_HI:CTRL_SERIAL_SELECT] <= control;
            ADDR_PORT_G: prdata[PG_BIT6:PG_BIT4] <= port_g;
            ADDR_PSW: prdata[PSW_BUSY] <= busy;
            ADDR_SHIFT: prdata[7:0] <= serial_shift_reg;
            ADDR_IRQ_STATUS: prdata[IRQ_DONE] <= irq_status;
            ADDR_IRQ_MASK: prdata[IRQ_DONE] <= irq_mask;
            default: pslverr <= 1'b1;
         endcase
      end
   end

   // ======================================================
   // Transfer state
   // ======================================================
   // Software start and abort win over hardware completion
   always_comb
   begin
      next_state = state;
      if (wr_psw)
      begin
         next_state = pwdata[PSW_BUSY] ? TWS_SHIFT : TWS_IDLE;
      end
      else if (last_edge)
      begin
         next_state = TWS_IDLE;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= TWS_IDLE;
      end
      else
      begin
         state <= next_state;
      end
   end

   // ======================================================
   // Master shift clock generator
   // ======================================================
   // Counts half periods while a master transfer is active
   assign tick = active && is_master && (half_cnt == half_period - CNT_ONE);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         half_cnt <= 10'h000;
      end
      else if (!(active && is_master) || tick)
      begin
         half_cnt <= 10'h000;
      end
      else
      begin
         half_cnt <= half_cnt + CNT_ONE;
      end
   end

   // Clock toggles on each tick, the last one too, then drops once idle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sk_master <= 1'b0;
      end
      else if (!(active && is_master) || (wr_psw && !pwdata[PSW_BUSY]))
      begin
         sk_master <= 1'b0;
      end
      else if (tick)
      begin
         sk_master <= !sk_master;
      end
   end

   // ======================================================
   // Shift clock edges
   // ======================================================
   // Previous synchronised slave clock level for edge finding
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sk_prev <= 1'b0;
      end
      else
      begin
         sk_prev <= sk_sync;
      end
   end

   // Edges from the internal or the external clock
   assign rise = is_master ? (tick && !sk_master) : (active && sk_sync && !sk_prev);
   assign fall = is_master ? (tick && sk_master) : (active && !sk_sync && sk_prev);

   assign shift_edge = clock_phase_select ? rise : fall;
   assign last_edge = active && shift_edge && (bit_cnt == LAST_BIT);

   // ======================================================
   // Shift register and bit counter
   // ======================================================
   // Input bit captured on the rising edge in normal phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         in_bit <= 1'b0;
      end
      else if (active && rise)
      begin
         in_bit <= si_sync;
      end
   end

   // Eight-bit shift register, MSB leaves first
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         serial_shift_reg <= SHIFT_RESET;
      end
      else if (wr_shift)
      begin
         serial_shift_reg <= pwdata[7:0];
      end
      else if (active && shift_edge)
      begin
         if (clock_phase_select)
         begin
            serial_shift_reg <= {serial_shift_reg[6:0], si_sync};
         end
         else
         begin
            serial_shift_reg <= {serial_shift_reg[6:0], in_bit};
         end
      end
   end

   // Bits shifted in the current transfer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bit_cnt <= 3'h0;
      end
      else if (wr_psw)
      begin
         bit_cnt <= 3'h0;
      end
      else if (active && shift_edge)
      begin
         bit_cnt <= bit_cnt + BIT_ONE;
      end
   end

   // ======================================================
   // Interrupt
   // ======================================================
   // Completion flag; a new completion wins over the read clear, and a read
   // clears only a set bit that it returned, so no completion is lost
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_status <= 1'b0;
      end
      else if (last_edge && !wr_psw)
      begin
         irq_status <= 1'b1;
      end
      else if (rd_irq && prdata[IRQ_DONE])
      begin
         irq_status <= 1'b0;
      end
   end

   assign irq = irq_status && irq_mask;

   // ======================================================
   // Pin drive
   // ======================================================
   // Output and clock pins are routed only with serial_select set
   assign serial_out_o = serial_shift_reg[7];
   assign serial_out_oe = serial_select && port_g_bit4;
   assign shift_clock_pin_o = sk_master;
   assign shift_clock_pin_oe = serial_select && port_g_bit5;

endmodule : tws_shifter

`default_nettype wire

// ===== rtl/tws_sync.sv
`timescale 1ns/1ps
`default_nettype none

module tws_sync
   import tws_pkg::*;
(
   input wire logic pclk, // System clock
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic async_in, // Level from outside the clock domain
   output logic sync_out // Level after two flip-flops
);

   logic meta;

   // ======================================================
   // Two-stage synchroniser
   // ======================================================
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         meta <= async_in;
         sync_out <= meta;
      end
   end

endmodule : tws_sync

`default_nettype wire

// ===== verif/three_wire_serial_shifter_test.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// Self-checking bench of the serial shifter
module three_wire_serial_shifter_test
   import tws_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, irq, so, so_oe, sk_o, sk_oe, p_do, p_sk, err_q;
   logic [7:0] tx, ptx;
   int checks = 0;
   int n_mismatch = 0;
   int cyc = 0;
   int rises = 0;
   int d;
   // Wire levels, data line pulled down and clock line taken from the peer when undriven
   wire sk_w = sk_oe ? sk_o : p_sk;
   wire so_w = so_oe ? so : 1'b0;
   tws_shifter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .serial_in_pin(p_do), .serial_out_o(so), .serial_out_oe(so_oe), .shift_clock_pin_i(sk_w),
      .shift_clock_pin_o(sk_o), .shift_clock_pin_oe(sk_oe));
   tws_peer_model peer (.sck(sk_w), .din(so_w), .dout(p_do), .sck_drv(p_sk));
   task automatic end_sim;
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer, held until pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // No limit of its own; the bench timeout ends a hang
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb
   // Half clock period for a rate code
   function automatic int half(input logic [1:0] rt);
      return rt[1] ? 4 * TC_CYCLES : (rt[0] ? 2 * TC_CYCLES : TC_CYCLES);
   endfunction : half
   // Configure, load both ends, start, poll busy
   task automatic xfer(input logic [2:0] ctl, input logic [31:0] pg, input bit slave);
      logic [31:0] q;
      int t0;
      apb(1, ADDR_CONTROL, {29'h0, ctl}, q);
      apb(1, ADDR_PORT_G, pg, q);
      tx = 8'($urandom);
      ptx = 8'($urandom);
      peer.tx = ptx;
      apb(1, ADDR_SHIFT, {24'h0, tx}, q);
      rises = 0;
      apb(1, ADDR_PSW, 32'h1, q);
      t0 = cyc;
      if (slave)
         peer.pulses(8);
      q = 32'h1;
      while (q[0] === 1'b1 && cyc - t0 < 20000)
         apb(0, ADDR_PSW, 0, q);
      d = cyc - t0;
      chk(q, 32'h0);
   endtask : xfer
   initial
   begin
      forever #2.5 pclk = ~pclk;
   end
   // Cycle count and hang limit
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         n_mismatch++;
         end_sim();
      end
   end
   always @(posedge sk_w) rises++;
   initial
   begin
      logic [31:0] q;
      int r;
      void'($urandom(32'h313395c1));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, ADDR_PORT_G, 0, q);
      chk(q, 32'h0);
      apb(0, ADDR_CONTROL, 0, q);
      chk(q, 32'h0);
      apb(0, 8'h20, 0, q);
      chk(err_q, 1);
      $display("done reset");
      apb(1, ADDR_IRQ_MASK, 32'h1, q);
      for (r = 0; r < 4; r++)
      begin
         xfer({r[1:0], 1'b1}, 32'h30, 0);
         chk(d >= 16 * half(r[1:0]) && d <= 16 * half(r[1:0]) + 10, 1);
         chk(rises, 8);
         chk(peer.rx, tx);
         apb(0, ADDR_SHIFT, 0, q);
         chk(q, {24'h0, ptx});
         chk(irq, 1);
         apb(0, ADDR_IRQ_STATUS, 0, q);
         chk(q, 32'h1);
         chk(irq, 0);
      end
      $display("done master");
      apb(1, ADDR_IRQ_MASK, 0, q);
      xfer(3'h1, 32'h30, 0);
      chk(irq, 0);
      apb(1, ADDR_IRQ_MASK, 32'h1, q);
      chk(irq, 1);
      apb(0, ADDR_IRQ_STATUS, 0, q);
      chk(irq, 0);
      $display("done mask");
      xfer(3'h1, 32'h70, 0);
      chk(rises, 8);
      chk(sk_w, 0);
      apb(0, ADDR_SHIFT, 0, q);
      chk(q, {24'h0, ptx});
      apb(0, ADDR_PORT_G, 0, q);
      chk(q, 32'h70);
      apb(0, ADDR_IRQ_STATUS, 0, q);
      $display("done alternate");
      apb(1, ADDR_PORT_G, 32'h30, q);
      rises = 0;
      apb(1, ADDR_PSW, 32'h1, q);
      repeat (1100) @(posedge pclk);
      apb(1, ADDR_PSW, 0, q);
      r = rises;
      repeat (1000) @(posedge pclk);
      chk(rises, r);
      chk(r < 8, 1);
      chk(sk_w, 0);
      apb(0, ADDR_IRQ_STATUS, 0, q);
      chk(q, 32'h0);
      $display("done abort");
      xfer(3'h1, 32'h10, 1);
      chk({so_oe, sk_oe}, 2'b10);
      chk(peer.rx, tx);
      apb(0, ADDR_SHIFT, 0, q);
      chk(q, {24'h0, ptx});
      apb(0, ADDR_IRQ_STATUS, 0, q);
      chk(q, 32'h1);
      $display("done slave");
      apb(1, ADDR_CONTROL, 0, q);
      apb(1, ADDR_PORT_G, 32'h30, q);
      rises = 0;
      apb(1, ADDR_PSW, 32'h1, q);
      repeat (600) @(posedge pclk);
      chk(rises, 0);
      chk({so_oe, sk_oe}, 2'b00);
      apb(0, ADDR_PSW, 0, q);
      chk(q, 32'h1);
      apb(1, ADDR_PSW, 0, q);
      $display("done deselected");
      end_sim();
   end
endmodule : three_wire_serial_shifter_test
bind tws_shifter tws_shifter_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .irq(irq), .serial_out_o(serial_out_o),
   .serial_out_oe(serial_out_oe), .shift_clock_pin_o(shift_clock_pin_o), .shift_clock_pin_oe(shift_clock_pin_oe));
`default_nettype wire

// ===== verif/tws_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// Far side device of the three wire link
module tws_peer_model
(
   input wire logic sck, // Clock on the wire
   input wire logic din, // Data from the block
   output logic dout, // Data to the block
   output logic sck_drv // Clock driven as master
);
   logic [7:0] tx = 8'h00;
   logic [7:0] rx = 8'h00;
   initial sck_drv = 1'b0;
   assign dout = tx[7];
   // Take data on the rising edge
   always @(posedge sck) rx <= {rx[6:0], din};
   // Next bit out on the falling edge, vacated bit toggles
   always @(negedge sck) tx <= {tx[6:0], ~tx[0]};
   // Clock pulses, 125 ns period, start and end low
   task automatic pulses(input int n);
      repeat (n)
      begin
         #62.5 sck_drv = 1'b1;
         #62.5 sck_drv = 1'b0;
      end
   endtask : pulses
endmodule : tws_peer_model
`default_nettype wire

// ===== verif/tws_shifter_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// Pin level checks of the serial shifter
module tws_shifter_asserts
   import tws_pkg::*;
(
   input wire logic pclk, // System clock
   input wire logic presetn, // Reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic irq, // Interrupt
   input wire logic serial_out_o, // Serial data out
   input wire logic serial_out_oe, // Data out enable
   input wire logic shift_clock_pin_o, // Master clock
   input wire logic shift_clock_pin_oe // Clock out enable
);
   logic [10:0] hi_cnt;
   logic [10:0] lo_cnt;
   logic acc;
   logic wr;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Access and write qualifiers
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   // Length of the present clock phase, low count saturates
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hi_cnt <= 11'h000;
         lo_cnt <= 11'h000;
      end
      else
      begin
         hi_cnt <= shift_clock_pin_o ? hi_cnt + 11'h001 : 11'h000;
         lo_cnt <= shift_clock_pin_o ? 11'h000 : lo_cnt + {10'h000, lo_cnt != 11'h7ff};
      end
   end
   chk_high_max: assert property ($fell(shift_clock_pin_o) |-> hi_cnt <= 11'(HALF_8TC))
      else $error("clock high too long");
   chk_low_min: assert property ($rose(shift_clock_pin_o) |-> lo_cnt >= 11'(HALF_2TC))
      else $error("clock low too short");
   chk_rise_master: assert property ($rose(shift_clock_pin_o) |-> shift_clock_pin_oe)
      else $error("clock toggles while slave");
   chk_abort_low: assert property (wr && paddr == ADDR_PSW && !pwdata[PSW_BUSY]
      |-> ##2 (!shift_clock_pin_o) [*8])
      else $error("clock runs after busy cleared");
   chk_so_enable: assert property ($changed(serial_out_oe)
      |-> $past(wr) && ($past(paddr) == ADDR_CONTROL || $past(paddr) == ADDR_PORT_G))
      else $error("data enable moved by itself");
   chk_sk_enable: assert property ($changed(shift_clock_pin_oe)
      |-> $past(wr) && ($past(paddr) == ADDR_CONTROL || $past(paddr) == ADDR_PORT_G))
      else $error("clock enable moved by itself");
   chk_out_edge: assert property ($changed(serial_out_o) && shift_clock_pin_oe
      |-> $rose(shift_clock_pin_o) || $fell(shift_clock_pin_o) || $past(wr))
      else $error("data out moved off a clock edge");
   chk_read_clear: assert property (acc && !pwrite && paddr == ADDR_IRQ_STATUS && $past(irq) |=> !irq)
      else $error("status read left irq high");
   chk_mask_off: assert property (wr && paddr == ADDR_IRQ_MASK && !pwdata[IRQ_DONE] |=> !irq)
      else $error("masked irq high");
endmodule : tws_shifter_asserts
`default_nettype wire
